// ===== rtl/gpio_audio_pin_function_mux.sv
// pin-function multiplexer for general, fast and register-only i/o lines
// assumes synchronous inputs at 100 MHz and a host that writes selections as plain ports
`timescale 1ns/10ps
`default_nettype none
module gpio_audio_pin_function_mux
	import pin_mux_pkg::*;
(
	input  wire logic       clk,                 // 100 MHz clock
	input  wire logic       rst_n,               // async reset, active low
	input  wire logic       powerDownRelease,    // active-high enable pin
	input  wire logic       dualLinkMode,        // link runs in dual mode
	input  wire logic       cfgWrite,            // strobe: capture configuration ports
	input  wire logic       cfgLineNineMclk,     // line nine carries system clock
	input  wire logic       cfgLineOneMasterWc,  // line one carries master word clock
	input  wire logic       cfgSlaveAudio,       // reg-only lines carry slave audio
	input  wire logic       cfgSlaveDataCd,      // lines 2,3 carry slave data c,d
	input  wire logic       cfgFastSpi,          // fast lines carry spi
	input  wire logic [3:0] cfgFastOe,           // fast line general output enables
	input  wire logic [3:0] cfgFastOut,          // fast line general output values
	input  wire logic [3:0] cfgRegOnlyOut,       // reg-only line values 5..8
	input  wire logic       cfgLineNineOut,      // general line nine value
	input  wire logic [2:0] cfgLineOut,          // general lines 1..3 values
	input  wire logic       masterSysClk,        // master audio system clock
	input  wire logic       masterWordClk,       // master audio word clock
	input  wire logic       slaveWordClk,        // slave audio word clock
	input  wire logic       slaveBitClk,         // slave audio bit clock
	input  wire logic [3:0] slaveData,           // slave audio data a..d
	input  wire logic       spiDataOut,          // spi data out from engine
	input  wire logic       spiClock,            // spi clock from engine
	input  wire logic       spiSelect,           // spi select from engine
	input  wire logic [3:0] fastIn,              // fast line pin levels
	output var  logic       spiDataIn,           // spi data in to engine
	output var  logic [3:0] fastOut,             // fast line pin drive
	output var  logic [3:0] fastOe,              // fast line output enable
	output var  logic [3:0] regOnlyOut,          // lines 5..8 drive
	output var  logic [3:0] regOnlyOe,           // lines 5..8 output enable
	output var  logic       lineNineOut,         // general line nine drive
	output var  logic       lineNineOe,          // general line nine enable
	output var  logic [2:0] lineOut,             // general lines 1..3 drive
	output var  logic [2:0] lineOe,              // general lines 1..3 enable
	output var  logic [1:0] linkState            // off / single / dual
);
	logic       restartPulse;
	logic       selMclk_reg, selMasterWc_reg, selSlave_reg, selCd_reg, selSpi_reg;
	logic [3:0] fastOeCfg_reg, fastOutCfg_reg, regOnlyCfg_reg;
	logic       lineNineCfg_reg;
	logic [2:0] lineCfg_reg;
	link_state_t linkState_reg, linkState_next;

	pdb_release_detect releaseDet (
		.clk             (clk),
		.rst_n           (rst_n),
		.powerDownRelease(powerDownRelease),
		.restartPulse    (restartPulse)
	);

	// any configuration write also needs the device enabled; a restart wins over a write
	wire cfgTake   = cfgWrite & powerDownRelease & ~restartPulse;
	wire clearCfg  = restartPulse | ~powerDownRelease;

	// configuration store
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			selMclk_reg     <= 1'h0;
			selMasterWc_reg <= 1'h0;
			selSlave_reg    <= 1'h0;
			selCd_reg       <= 1'h0;
			selSpi_reg      <= FAST_FN_GPIO;
			fastOeCfg_reg   <= FAST_OE_RST;
			fastOutCfg_reg  <= FAST_OUT_RST;
			regOnlyCfg_reg  <= REG_ONLY_OUT_RST;
			lineNineCfg_reg <= LINE_OUT_RST;
			lineCfg_reg     <= 3'h0;
		end else if (clearCfg) begin
			selMclk_reg     <= 1'h0;
			selMasterWc_reg <= 1'h0;
			selSlave_reg    <= 1'h0;
			selCd_reg       <= 1'h0;
			selSpi_reg      <= FAST_FN_GPIO;
			fastOeCfg_reg   <= FAST_OE_RST;
			fastOutCfg_reg  <= FAST_OUT_RST;
			regOnlyCfg_reg  <= REG_ONLY_OUT_RST;
			lineNineCfg_reg <= LINE_OUT_RST;
			lineCfg_reg     <= 3'h0;
		end else if (cfgTake) begin
			selMclk_reg     <= cfgLineNineMclk;
			selMasterWc_reg <= cfgLineOneMasterWc;
			selSlave_reg    <= cfgSlaveAudio;
			selCd_reg       <= cfgSlaveDataCd;
			selSpi_reg      <= cfgFastSpi;
			fastOeCfg_reg   <= cfgFastOe;
			fastOutCfg_reg  <= cfgFastOut;
			regOnlyCfg_reg  <= cfgRegOnlyOut;
			lineNineCfg_reg <= cfgLineNineOut;
			lineCfg_reg     <= cfgLineOut;
		end
	end

	// link state follows the enable pin and the dual-link indication
	always_comb begin
		unique case (linkState_reg)
			LINK_OFF:    linkState_next = !powerDownRelease ? LINK_OFF :
			                              (dualLinkMode ? LINK_DUAL : LINK_SINGLE);
			LINK_SINGLE: linkState_next = !powerDownRelease ? LINK_OFF :
			                              (dualLinkMode ? LINK_DUAL : LINK_SINGLE);
			LINK_DUAL:   linkState_next = !powerDownRelease ? LINK_OFF :
			                              (dualLinkMode ? LINK_DUAL : LINK_SINGLE);
			default:     linkState_next = LINK_OFF;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			linkState_reg <= LINK_OFF;
		else if (restartPulse)
			linkState_reg <= LINK_OFF;
		else
			linkState_reg <= linkState_next;
	end

	// fast lines: dead outside dual link, so single-link pins stay floating
	wire        fastUsable = (linkState_reg == LINK_DUAL);
	wire        spiOn      = fastUsable & (selSpi_reg == FAST_FN_SPI);
	wire [3:0]  spiDrive   = {spiSelect, spiClock, 1'h0, spiDataOut};
	// data-in pin is an input in spi use; the other three are driven
	wire [3:0]  spiOe      = 4'hd;
	wire [3:0]  fastOutNext = spiOn ? spiDrive : fastOutCfg_reg;
	wire [3:0]  fastOeNext  = !fastUsable ? 4'h0 : (spiOn ? spiOe : fastOeCfg_reg);

	// reg-only lines; jitter cleaner state is the host's duty and is not checked here
	wire [3:0]  slaveDrive = {slaveBitClk, slaveWordClk, slaveData[0], slaveData[1]};
	wire [3:0]  regOnlyNext = selSlave_reg ? slaveDrive : regOnlyCfg_reg;

	// general lines 1..3: line one may be master word clock, 2/3 slave data c/d
	wire        lineOneNext = selMasterWc_reg ? masterWordClk : lineCfg_reg[0];
	wire [1:0]  lineCdNext  = selCd_reg ? slaveData[3:2] : lineCfg_reg[2:1];
	wire        lineNineNext = selMclk_reg ? masterSysClk : lineNineCfg_reg;

	// every pin output is registered so glitches of the select logic never reach a pad
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fastOut     <= FAST_OUT_RST;
			fastOe      <= FAST_OE_RST;
			regOnlyOut  <= REG_ONLY_OUT_RST;
			regOnlyOe   <= REG_ONLY_OE_RST;
			lineNineOut <= LINE_OUT_RST;
			lineNineOe  <= LINE_OE_RST;
			lineOut     <= 3'h0;
			lineOe      <= 3'h7;
			spiDataIn   <= 1'h0;
			linkState   <= 2'h0;
		end else begin
			fastOut     <= fastOutNext;
			fastOe      <= fastOeNext;
			regOnlyOut  <= regOnlyNext;
			regOnlyOe   <= REG_ONLY_OE_RST;
			lineNineOut <= lineNineNext;
			lineNineOe  <= LINE_OE_RST;
			lineOut     <= {lineCdNext, lineOneNext};
			lineOe      <= 3'h7;
			spiDataIn   <= spiOn & fastIn[SPI_DIN_IDX];
			linkState   <= linkState_reg;
		end
	end

	// checks
	fast_off_single_a: assert property (@(posedge clk) disable iff (!rst_n)
		(linkState_reg != LINK_DUAL) |=> (fastOe == 4'h0))
		else $error("fast line driven outside dual link");
	restart_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
		restartPulse |=> (!selSlave_reg && !selSpi_reg && !selMclk_reg && regOnlyCfg_reg == 4'h0))
		else $error("restart did not restore defaults");
	slave_bck_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		selSlave_reg |=> (regOnlyOut[SLV_BCK_IDX] == $past(slaveBitClk)))
		else $error("slave bit clock not on line eight");
	slave_da_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		selSlave_reg |=> (regOnlyOut[SLV_DA_IDX] == $past(slaveData[0])))
		else $error("slave data a not on line six");
	master_wc_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		selMasterWc_reg |=> (lineOut[0] == $past(masterWordClk)))
		else $error("master word clock not on line one");
	data_cd_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		selCd_reg |=> (lineOut[2:1] == $past(slaveData[3:2])))
		else $error("slave data c d not on lines two three");
	mclk_line_nine_a: assert property (@(posedge clk) disable iff (!rst_n)
		selMclk_reg |=> (lineNineOut == $past(masterSysClk)))
		else $error("system clock not on line nine");
	spi_clock_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		spiOn |=> (fastOut[SPI_CLK_IDX] == $past(spiClock) && fastOe == 4'hd))
		else $error("spi clock not on fast line two");
	reg_only_gpio_a: assert property (@(posedge clk) disable iff (!rst_n)
		!selSlave_reg |=> (regOnlyOut == $past(regOnlyCfg_reg)))
		else $error("reg-only line not from register");
	fast_default_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		clearCfg |=> (fastOeCfg_reg == FAST_OE_RST && selSpi_reg == FAST_FN_GPIO))
		else $error("fast line defaults not restored");
	restart_drop_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		(restartPulse && cfgWrite) |=> (!selSlave_reg && !selMclk_reg && !selMasterWc_reg && !selCd_reg && !selSpi_reg))
		else $error("write taken during restart");
	spi_data_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		spiOn |=> (fastOut[SPI_DOUT_IDX] == $past(spiDataOut) && fastOut[SPI_SEL_IDX] == $past(spiSelect)))
		else $error("general driver not cut off in spi use");
	link_dual_on_a: assert property (@(posedge clk) disable iff (!rst_n)
		(powerDownRelease && dualLinkMode && !restartPulse) |=> (linkState_reg == LINK_DUAL))
		else $error("dual link not entered");
	slave_wc_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		selSlave_reg |=> (regOnlyOut[SLV_WC_IDX] == $past(slaveWordClk) && regOnlyOut[SLV_DB_IDX] == $past(slaveData[1])))
		else $error("slave word clock or data b not on lines seven five");
	line_nine_gpio_a: assert property (@(posedge clk) disable iff (!rst_n)
		!selMclk_reg |=> (lineNineOut == $past(lineNineCfg_reg)))
		else $error("line nine not from register");
endmodule
`default_nettype wire

// ===== rtl/pin_mux_pkg.sv
// package for the pin-function multiplexer: select codes, pin indices, defaults
// assumes one 100 MHz clock domain and no register bus (selections arrive as ports)
package pin_mux_pkg;

	// number of pins of the fast and reg-only groups
	localparam int FAST_COUNT    = 4;
	localparam int REG_ONLY_COUNT = 4;

	// fast line function select: general i/o or spi
	localparam logic FAST_FN_GPIO = 1'h0;
	localparam logic FAST_FN_SPI  = 1'h1;

	// spi signal order on fast lines 0..3: data out, data in, clock, select
	localparam int SPI_DOUT_IDX = 0;
	localparam int SPI_DIN_IDX  = 1;
	localparam int SPI_CLK_IDX  = 2;
	localparam int SPI_SEL_IDX  = 3;

	// reg-only lines 5..8 map to index 0..3: data b, data a, word clock, bit clock
	localparam int SLV_DB_IDX  = 0;
	localparam int SLV_DA_IDX  = 1;
	localparam int SLV_WC_IDX  = 2;
	localparam int SLV_BCK_IDX = 3;

	// default output levels and enables after reset
	localparam logic [3:0] REG_ONLY_OUT_RST = 4'h0;
	localparam logic [3:0] REG_ONLY_OE_RST  = 4'hf;
	localparam logic [3:0] FAST_OUT_RST     = 4'h0;
	localparam logic [3:0] FAST_OE_RST      = 4'h0;
	localparam logic       LINE_OUT_RST     = 1'h0;
	localparam logic       LINE_OE_RST      = 1'h1;

	// synchroniser depth for the power-down release input; unused, the release detector samples the input directly
	localparam int PDB_SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		LINK_OFF    = 2'h0,
		LINK_SINGLE = 2'h1,
		LINK_DUAL   = 2'h3
	} link_state_t;

endpackage

// ===== rtl/pdb_release_detect.sv
// rising-edge detector on the power-down release input
// assumes the input is synchronous to clk; emits a one-cycle restart pulse
`timescale 1ns/10ps
`default_nettype none
module pdb_release_detect
	import pin_mux_pkg::*;
(
	input  wire logic clk,           // system clock
	input  wire logic rst_n,         // async reset, active low
	input  wire logic powerDownRelease, // active-high enable pin level
	output var  logic restartPulse   // one cycle on the rising edge
);
	logic prevLevel_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prevLevel_reg <= 1'h0;
			restartPulse  <= 1'h0;
		end else begin
			prevLevel_reg <= powerDownRelease;
			restartPulse  <= powerDownRelease & ~prevLevel_reg;
		end
	end
endmodule
`default_nettype wire

// ===== test/fast_line_partner.sv
// far-side model of the fast lines: spi peripheral and pin pulldowns
// assumes the bench says when the peripheral answers on data-in
`timescale 1ns/10ps
`default_nettype none
module fast_line_partner (
	input  wire logic [3:0] pinOut,   // device drive
	input  wire logic [3:0] pinOe,    // device enable
	input  wire logic       respond,  // peripheral drives data-in
	input  wire logic       respData, // peripheral data-in level
	output var  logic [3:0] pinLevel  // resolved pin levels
);
	// released lines fall to the weak pulldown unless the peripheral answers on data-in, never keep the last value
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pinLevel[i] = pinOe[i] ? pinOut[i] : 1'h0;
		end
		if (!pinOe[1] && respond) begin
			pinLevel[1] = respData;
		end
	end
endmodule
`default_nettype wire

// ===== test/gpio_audio_pin_function_mux_tb_top.sv
// self-checking bench for the pin-function multiplexer, model compared every cycle
// assumes the package, the design and fast_line_partner are compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
	$display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module gpio_audio_pin_function_mux_tb_top;
	import pin_mux_pkg::*;
	logic       clk, rst_n, powerDownRelease, dualLinkMode, cfgWrite, respond, respData;
	logic       cfgLineNineMclk, cfgLineOneMasterWc, cfgSlaveAudio, cfgSlaveDataCd, cfgFastSpi, cfgLineNineOut;
	logic       masterSysClk, masterWordClk, slaveWordClk, slaveBitClk, spiDataOut, spiClock, spiSelect;
	logic       spiDataIn, lineNineOut, lineNineOe;
	logic [3:0] cfgFastOe, cfgFastOut, cfgRegOnlyOut, slaveData, fastIn, fastOut, fastOe, regOnlyOut, regOnlyOe;
	logic [2:0] cfgLineOut, lineOut, lineOe;
	logic [1:0] linkState, eLink, eLinkQ;
	logic       mNine, mWc, mSlv, mCd, mSpi, mNout, eNine, eSdi, eSdiOk, mRp, mPrev;
	logic [3:0] mFoe, mFout, mRout, eReg, eFoe, eFout;
	logic [2:0] mLout, eLine;
	logic [31:0] r;
	int         errors, compares, skip, cycles;

	gpio_audio_pin_function_mux i_dut (.clk, .rst_n, .powerDownRelease, .dualLinkMode, .cfgWrite,
		.cfgLineNineMclk, .cfgLineOneMasterWc, .cfgSlaveAudio, .cfgSlaveDataCd, .cfgFastSpi, .cfgFastOe,
		.cfgFastOut, .cfgRegOnlyOut, .cfgLineNineOut, .cfgLineOut, .masterSysClk, .masterWordClk,
		.slaveWordClk, .slaveBitClk, .slaveData, .spiDataOut, .spiClock, .spiSelect, .fastIn, .spiDataIn,
		.fastOut, .fastOe, .regOnlyOut, .regOnlyOe, .lineNineOut, .lineNineOe, .lineOut, .lineOe, .linkState);
	fast_line_partner i_partner (.pinOut(fastOut), .pinOe(fastOe), .respond, .respData, .pinLevel(fastIn));

	always #5 clk = ~clk;

	// sources change every cycle so a stale pin shows up
	always @(posedge clk) begin
		r = $urandom;
		{masterSysClk, masterWordClk, slaveWordClk, slaveBitClk, spiDataOut, spiClock, spiSelect, respData} <= r[7:0];
		slaveData <= r[11:8];
	end

	// expected pins after edge k come from config held before k and sources sampled at k
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{mNine, mWc, mSlv, mCd, mSpi, mNout, mFoe, mFout, mRout, mLout} = '0;
			{eNine, eSdi, eSdiOk, eLine, eReg, eFoe, eFout} = '0;
			eLink = LINK_OFF;
			eLinkQ = LINK_OFF;
			{mRp, mPrev} = '0;
			skip = 1;
		end else begin
			if (skip == 0) begin
				`CHK("lineNineOut", eNine, lineNineOut)
				`CHK("lineOut", eLine, lineOut)
				`CHK("regOnlyOut", eReg, regOnlyOut)
				`CHK("fixedOe", 8'hff, {lineNineOe, lineOe, regOnlyOe})
				`CHK("fastOe", eFoe, fastOe)
				`CHK("fastOut", eFout, fastOut)
				`CHK("linkState", eLinkQ, linkState)
				`CHK("spiDataIn", eSdi, spiDataIn)
			end else begin
				skip--;
			end
			eFoe = (eLink == LINK_DUAL) ? (mSpi ? 4'hd : mFoe) : 4'h0;
			eFout = (eLink == LINK_DUAL && mSpi) ? {spiSelect, spiClock, 1'h0, spiDataOut} : mFout;
			eSdiOk = (eLink == LINK_DUAL) && mSpi;
			eSdi = eSdiOk & fastIn[1];
			eNine = mNine ? masterSysClk : mNout;
			eLine = {mCd ? slaveData[3:2] : mLout[2:1], mWc ? masterWordClk : mLout[0]};
			eReg = mSlv ? {slaveBitClk, slaveWordClk, slaveData[0], slaveData[1]} : mRout;
			// pin output of the link state trails the state itself by one edge
			eLinkQ = eLink;
			eLink = (mRp || !powerDownRelease) ? LINK_OFF : (dualLinkMode ? LINK_DUAL : LINK_SINGLE);
			// a write in the cycle after the release edge is lost to the restart
			if (mRp || !powerDownRelease) begin
				{mNine, mWc, mSlv, mCd, mSpi, mNout, mFoe, mFout, mRout, mLout} = '0;
			end else if (cfgWrite) begin
				{mNine, mWc, mSlv, mCd, mSpi, mNout, mFoe, mFout, mRout, mLout} = {cfgLineNineMclk,
					cfgLineOneMasterWc, cfgSlaveAudio, cfgSlaveDataCd, cfgFastSpi, cfgLineNineOut,
					cfgFastOe, cfgFastOut, cfgRegOnlyOut, cfgLineOut};
			end
			mRp = powerDownRelease & ~mPrev;
			mPrev = powerDownRelease;
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			give_verdict();
		end
	end

	// back-to-back random selections; spi only where the phase allows it
	task automatic write_cfg(input int n, input bit spiOk);
		logic [31:0] v;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			v = $urandom;
			cfgWrite <= 1'h1;
			// host keeps the jitter cleaner off whenever slave clocks go out
			{cfgLineNineMclk, cfgLineOneMasterWc, cfgSlaveAudio, cfgLineNineOut, cfgFastOe, cfgFastOut,
				cfgRegOnlyOut, cfgLineOut} <= v[18:0];
			cfgSlaveDataCd <= v[16] & v[19];
			cfgFastSpi <= v[20] & spiOk;
			respond <= v[20] & spiOk;
		end
		@(posedge clk);
		cfgWrite <= 1'h0;
		repeat (6) @(posedge clk);
	endtask

	task automatic give_verdict();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		clk = 1'h0;
		rst_n = 1'h0;
		powerDownRelease = 1'h1;
		dualLinkMode = 1'h1;
		{cfgWrite, respond, cfgLineNineMclk, cfgLineOneMasterWc, cfgSlaveAudio, cfgSlaveDataCd} = '0;
		{cfgFastSpi, cfgLineNineOut, cfgFastOe, cfgFastOut, cfgRegOnlyOut, cfgLineOut} = '0;
		{masterSysClk, masterWordClk, slaveWordClk, slaveBitClk, spiDataOut, spiClock, spiSelect} = '0;
		respData = 1'h0;
		slaveData = 4'h0;
		errors = 0;
		compares = 0;
		cycles = 0;
		skip = 3;
		void'($urandom(35));
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		repeat (8) @(posedge clk);
		write_cfg(24, 1'h1);
		dualLinkMode <= 1'h0;
		write_cfg(24, 1'h1);
		dualLinkMode <= 1'h1;
		write_cfg(6, 1'h1);
		powerDownRelease <= 1'h0;
		write_cfg(2, 1'h1);
		powerDownRelease <= 1'h1;
		// first write lands in the restart cycle and must be dropped
		write_cfg(8, 1'h1);
		give_verdict();
	end
endmodule
`undef CHK
`default_nettype wire
